// [verilog/coag_pkg.sv]
// Summary of operation
// - accumulator mode: no operand bytes, operation acts on the accumulator
// - immediate mode: operand is the byte after the opcode, no further access
// - absolute mode: first operand byte is address low, second is high
// - zero page mode: one operand byte, high address byte forced to zero
// - indexed zero page: byte plus index modulo 256, stays in page zero
// - indexed absolute: X or Y added to the 16-bit operand address
// - implied mode: location follows from the opcode, no operand fetch
// - branches add a signed offset to the next-instruction program counter
// - pre-indexed indirect: byte plus X picks a page-zero pointer, low then high
// - post-indexed indirect: Y added to pointer low, carry into pointer high
// - absolute indirect: pointer bytes read and loaded into the program counter
// - clear or set carry, decimal, interrupt mask; clear overflow only
// - transfers accumulator to X and Y, back, stack pointer to X, X to it
// - push and pull the accumulator or the status on the stack
// - compare memory with accumulator, X or Y, only flags change
// - increment or decrement memory, X or Y by one
// - shift or rotate one bit, accumulator or memory
// - branches on carry, zero, negative and overflow, clear or set
// - subroutine call saves return address, return restores it, plain jump
package coag_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] SP_RST = 8'hff;
  localparam logic [7:0] ACC_RST = 8'h00;
  // irq mask set and the unused bit held high out of reset
  localparam logic [7:0] STATUS_RST = 8'h24;
  // status bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_I = 2;
  localparam int FLAG_D = 3;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;
  // register select for the direct load port
  localparam logic [1:0] SEL_ACC = 2'h0;
  localparam logic [1:0] SEL_X = 2'h1;
  localparam logic [1:0] SEL_Y = 2'h2;
  localparam logic [1:0] SEL_SP = 2'h3;

  typedef enum logic [3:0] {
    mode_acc = 4'h0, mode_imm = 4'h1, mode_abs = 4'h2, mode_zp = 4'h3,
    mode_zpx = 4'h4, mode_zpy = 4'h5, mode_absx = 4'h6, mode_absy = 4'h7,
    mode_impl = 4'h8, mode_rel = 4'h9, mode_indx = 4'ha, mode_indy = 4'hb,
    mode_ind = 4'hc
  } coag_mode_t;

  typedef enum logic [5:0] {
    nop_op = 6'h00, carry_clear_op = 6'h01, carry_set_op = 6'h02,
    decimal_clear_op = 6'h03, decimal_set_op = 6'h04, irq_mask_clear_op = 6'h05,
    irq_mask_set_op = 6'h06, overflow_clear_op = 6'h07, acc_to_x_op = 6'h08,
    acc_to_y_op = 6'h09, x_to_acc_op = 6'h0a, y_to_acc_op = 6'h0b,
    sp_to_x_op = 6'h0c, x_to_sp_op = 6'h0d, push_acc_op = 6'h0e,
    pull_acc_op = 6'h0f, push_status_op = 6'h10, pull_status_op = 6'h11,
    compare_acc_op = 6'h12, compare_x_op = 6'h13, compare_y_op = 6'h14,
    mem_increment_op = 6'h15, mem_decrement_op = 6'h16, x_increment_op = 6'h17,
    x_decrement_op = 6'h18, y_increment_op = 6'h19, y_decrement_op = 6'h1a,
    shift_left_op = 6'h1b, shift_right_op = 6'h1c, rotate_left_op = 6'h1d,
    rotate_right_op = 6'h1e, branch_carry_clear = 6'h1f, branch_carry_set = 6'h20,
    branch_zero = 6'h21, branch_nonzero = 6'h22, branch_negative = 6'h23,
    branch_positive = 6'h24, branch_overflow_clear = 6'h25,
    branch_overflow_set = 6'h26, call_subroutine_op = 6'h27,
    return_sub_op = 6'h28, jump_op = 6'h29
  } coag_op_t;

  typedef enum logic [2:0] {
    alu_pass = 3'h0, alu_inc = 3'h1, alu_decr = 3'h2, alu_shl = 3'h3,
    alu_shr = 3'h4, alu_rotl = 3'h5, alu_rotr = 3'h6, alu_sub = 3'h7
  } coag_alu_t;

  typedef enum logic [3:0] {
    st_idle = 4'h0, st_oplo = 4'h1, st_ophi = 4'h2, st_ptrlo = 4'h3,
    st_ptrhi = 4'h4, st_read = 4'h5, st_exec = 4'h6, st_write = 4'h7,
    st_pushhi = 4'h8, st_pushlo = 4'h9, st_pulllo = 4'ha, st_pullhi = 4'hb
  } coag_state_t;
endpackage : coag_pkg

// [verilog/coag_alu.sv]
`timescale 1ns/1ns
module coag_alu
  import coag_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // function and operands
  input wire coag_alu_t i_fn,
  input wire logic [WIDTH-1:0] i_val,
  input wire logic [WIDTH-1:0] i_ref,
  input wire logic i_carry,
  // result and flags
  output logic [WIDTH-1:0] o_res,
  output logic o_carry,
  output logic o_neg,
  output logic o_zero
);
  logic [WIDTH:0] diff;

  if (WIDTH < 2) begin : g_bad_width
    $error("coag_alu needs at least two bits");
  end

  // compare subtracts without storing; carry set means no borrow
  assign diff = {1'b0, i_ref} - {1'b0, i_val};

  // one-bit shifts pull the old carry in on rotates only
  always_comb begin
    o_res = i_val;
    o_carry = i_carry;
    unique case (i_fn)
      alu_pass: o_res = i_val;
      alu_inc: o_res = i_val + WIDTH'(1);
      alu_decr: o_res = i_val - WIDTH'(1);
      alu_shl: {o_carry, o_res} = {i_val, 1'b0};
      alu_shr: {o_res, o_carry} = {1'b0, i_val};
      alu_rotl: {o_carry, o_res} = {i_val, i_carry};
      alu_rotr: {o_res, o_carry} = {i_carry, i_val};
      alu_sub: begin
        o_res = diff[WIDTH-1:0];
        o_carry = ~diff[WIDTH];
      end
    endcase
  end

  assign o_neg = o_res[WIDTH-1];
  assign o_zero = (o_res == '0);
endmodule : coag_alu

// [verilog/coag_core.sv]
`timescale 1ns/1ns
module coag_core
  import coag_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // decoded instruction request
  input wire logic i_start,
  input wire coag_op_t i_op,
  input wire coag_mode_t i_mode,
  output logic o_busy,
  output logic o_done,
  // direct register loads, honoured only while idle
  input wire logic i_pc_load,
  input wire logic [AW-1:0] i_pc_val,
  input wire logic i_reg_load,
  input wire logic [1:0] i_reg_sel,
  input wire logic [DW-1:0] i_reg_val,
  // byte-wide memory, read data valid in the cycle of the read strobe
  output logic [AW-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [DW-1:0] o_mem_wdata,
  input wire logic [DW-1:0] i_mem_rdata,
  // programmer-visible state
  output logic [AW-1:0] o_pc,
  output logic [DW-1:0] o_acc,
  output logic [DW-1:0] o_x,
  output logic [DW-1:0] o_y,
  output logic [DW-1:0] o_sp,
  output logic [DW-1:0] o_status,
  output logic [AW-1:0] o_ea
);
  coag_state_t state_r, state_nxt;
  coag_op_t op_r;
  coag_mode_t mode_r;
  logic [AW-1:0] pc_r, ea_r, ptr_r;
  logic [DW-1:0] acc_r, x_r, y_r, sp_r, status_r, lo_r, val_r;
  logic done_r;
  logic [DW-1:0] idx, alu_val, alu_ref, alu_res;
  logic [DW:0] indy_sum;
  logic alu_c, alu_n, alu_z, idle, taken;
  coag_alu_t alu_fn;

  if (DW != 8 || AW != 16) begin : g_bad_width
    $error("coag_core serves only 8-bit data and 16-bit addresses");
  end

  // modes that carry a single operand byte
  function automatic logic one_byte(coag_mode_t m);
    one_byte = m inside {mode_imm, mode_zp, mode_zpx, mode_zpy, mode_rel,
                         mode_indx, mode_indy};
  endfunction : one_byte

  // ops that need the byte at the effective address
  function automatic logic reads_mem(coag_op_t op, coag_mode_t m);
    reads_mem = op inside {compare_acc_op, compare_x_op, compare_y_op,
                           mem_increment_op, mem_decrement_op} ||
                (op inside {shift_left_op, shift_right_op, rotate_left_op,
                            rotate_right_op} && m != mode_acc);
  endfunction : reads_mem

  // ops whose result goes back to memory
  function automatic logic writes_mem(coag_op_t op, coag_mode_t m);
    writes_mem = reads_mem(op, m) && !(op inside {compare_acc_op, compare_x_op,
                                                  compare_y_op});
  endfunction : writes_mem

  function automatic logic sets_nz(coag_op_t op);
    sets_nz = op inside {acc_to_x_op, acc_to_y_op, x_to_acc_op, y_to_acc_op,
                         sp_to_x_op, compare_acc_op, compare_x_op, compare_y_op,
                         mem_increment_op, mem_decrement_op, x_increment_op,
                         x_decrement_op, y_increment_op, y_decrement_op,
                         shift_left_op, shift_right_op, rotate_left_op,
                         rotate_right_op};
  endfunction : sets_nz

  function automatic logic br_taken(coag_op_t op, logic [7:0] p);
    case (op)
      branch_carry_clear: br_taken = !p[FLAG_C];
      branch_carry_set: br_taken = p[FLAG_C];
      branch_zero: br_taken = p[FLAG_Z];
      branch_nonzero: br_taken = !p[FLAG_Z];
      branch_negative: br_taken = p[FLAG_N];
      branch_positive: br_taken = !p[FLAG_N];
      branch_overflow_clear: br_taken = !p[FLAG_V];
      branch_overflow_set: br_taken = p[FLAG_V];
      default: br_taken = 1'b0;
    endcase
  endfunction : br_taken

  assign idle = (state_r == st_idle);
  assign idx = (mode_r inside {mode_zpy, mode_absy, mode_indy}) ? y_r : x_r;
  assign indy_sum = {1'b0, lo_r} + {1'b0, y_r};
  assign taken = br_taken(op_r, status_r);

  // sequencer: only the bytes that a mode needs are fetched
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle: if (i_start) state_nxt = (i_mode inside {mode_acc, mode_impl}) ?
                                         st_exec : st_oplo;
      st_oplo: begin
        if (!one_byte(mode_r)) state_nxt = st_ophi;
        else if (mode_r inside {mode_indx, mode_indy}) state_nxt = st_ptrlo;
        else if (mode_r inside {mode_imm, mode_rel}) state_nxt = st_exec;
        else state_nxt = reads_mem(op_r, mode_r) ? st_read : st_exec;
      end
      st_ophi: begin
        if (mode_r == mode_ind) state_nxt = st_ptrlo;
        else state_nxt = reads_mem(op_r, mode_r) ? st_read : st_exec;
      end
      st_ptrlo: state_nxt = st_ptrhi;
      st_ptrhi: begin
        if (mode_r == mode_ind) state_nxt = st_idle;
        else state_nxt = reads_mem(op_r, mode_r) ? st_read : st_exec;
      end
      st_read: state_nxt = st_exec;
      st_exec: begin
        if (writes_mem(op_r, mode_r)) state_nxt = st_write;
        else if (op_r inside {push_acc_op, push_status_op}) state_nxt = st_pushlo;
        else if (op_r == call_subroutine_op) state_nxt = st_pushhi;
        else if (op_r inside {pull_acc_op, pull_status_op, return_sub_op})
          state_nxt = st_pulllo;
        else state_nxt = st_idle;
      end
      st_write: state_nxt = st_idle;
      st_pushhi: state_nxt = st_pushlo;
      st_pushlo: state_nxt = st_idle;
      st_pulllo: state_nxt = (op_r == return_sub_op) ? st_pullhi : st_idle;
      st_pullhi: state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) state_r <= st_idle;
    else state_r <= state_nxt;
  end

  // request capture; a start while busy is ignored
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      op_r <= nop_op;
      mode_r <= mode_impl;
    end else if (idle && i_start) begin
      op_r <= i_op;
      mode_r <= i_mode;
    end
  end

  // done marks the cycle after the last step of an instruction
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) done_r <= 1'b0;
    else done_r <= !idle && (state_nxt == st_idle);
  end

  // operand bytes, pointers and effective address
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      lo_r <= '0;
      ptr_r <= '0;
      ea_r <= '0;
    end else begin
      unique case (state_r)
        st_oplo: begin
          lo_r <= i_mem_rdata;
          if (mode_r == mode_zp) ea_r <= {ZERO_PAGE, i_mem_rdata};
          if (mode_r inside {mode_zpx, mode_zpy})
            ea_r <= {ZERO_PAGE, i_mem_rdata + idx};
          if (mode_r == mode_indx) ptr_r <= {ZERO_PAGE, i_mem_rdata + x_r};
          if (mode_r == mode_indy) ptr_r <= {ZERO_PAGE, i_mem_rdata};
        end
        st_ophi: begin
          if (mode_r == mode_abs) ea_r <= {i_mem_rdata, lo_r};
          // full 16-bit add, so a page crossing reaches the next page
          if (mode_r inside {mode_absx, mode_absy})
            ea_r <= {i_mem_rdata, lo_r} + {ZERO_PAGE, idx};
          if (mode_r == mode_ind) ptr_r <= {i_mem_rdata, lo_r};
        end
        st_ptrlo: lo_r <= i_mem_rdata;
        st_ptrhi: begin
          if (mode_r == mode_indx) ea_r <= {i_mem_rdata, lo_r};
          if (mode_r == mode_indy)
            ea_r <= {i_mem_rdata + {7'h00, indy_sum[DW]}, indy_sum[DW-1:0]};
        end
        st_pulllo: lo_r <= i_mem_rdata;
        default: ;
      endcase
    end
  end

  // operand value; exec leaves the modified byte here for the write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) val_r <= '0;
    else if (state_r == st_read || (state_r == st_oplo && one_byte(mode_r)))
      val_r <= i_mem_rdata;
    else if (state_r == st_exec) val_r <= alu_res;
  end

  // alu source and function per operation
  always_comb begin
    alu_fn = alu_pass;
    alu_val = val_r;
    alu_ref = acc_r;
    unique case (op_r)
      acc_to_x_op, acc_to_y_op: alu_val = acc_r;
      x_to_acc_op, x_to_sp_op: alu_val = x_r;
      y_to_acc_op: alu_val = y_r;
      sp_to_x_op: alu_val = sp_r;
      compare_acc_op: alu_fn = alu_sub;
      compare_x_op: begin
        alu_fn = alu_sub;
        alu_ref = x_r;
      end
      compare_y_op: begin
        alu_fn = alu_sub;
        alu_ref = y_r;
      end
      mem_increment_op: alu_fn = alu_inc;
      mem_decrement_op: alu_fn = alu_decr;
      x_increment_op, x_decrement_op: begin
        alu_fn = (op_r == x_increment_op) ? alu_inc : alu_decr;
        alu_val = x_r;
      end
      y_increment_op, y_decrement_op: begin
        alu_fn = (op_r == y_increment_op) ? alu_inc : alu_decr;
        alu_val = y_r;
      end
      shift_left_op, shift_right_op, rotate_left_op, rotate_right_op: begin
        alu_fn = (op_r == shift_left_op) ? alu_shl : (op_r == shift_right_op) ?
                 alu_shr : (op_r == rotate_left_op) ? alu_rotl : alu_rotr;
        alu_val = (mode_r == mode_acc) ? acc_r : val_r;
      end
      default: ;
    endcase
  end

  coag_alu #(.WIDTH(DW)) u_alu (
    .i_fn(alu_fn),
    .i_val(alu_val),
    .i_ref(alu_ref),
    .i_carry(status_r[FLAG_C]),
    .o_res(alu_res),
    .o_carry(alu_c),
    .o_neg(alu_n),
    .o_zero(alu_z)
  );

  // program counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) pc_r <= PC_RST;
    else if (idle && i_pc_load) pc_r <= i_pc_val;
    else if (state_r inside {st_oplo, st_ophi}) pc_r <= pc_r + ADDR_ONE;
    else if (state_r == st_ptrhi && mode_r == mode_ind)
      pc_r <= {i_mem_rdata, lo_r};
    else if (state_r == st_exec && taken)
      pc_r <= pc_r + {{DW{val_r[DW-1]}}, val_r};
    else if (state_r == st_exec && op_r == jump_op) pc_r <= ea_r;
    else if (state_r == st_pushlo && op_r == call_subroutine_op) pc_r <= ea_r;
    else if (state_r == st_pullhi) pc_r <= {i_mem_rdata, lo_r};
  end

  // accumulator
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) acc_r <= ACC_RST;
    else if (idle && i_reg_load && i_reg_sel == SEL_ACC) acc_r <= i_reg_val;
    else if (state_r == st_pulllo && op_r == pull_acc_op) acc_r <= i_mem_rdata;
    else if (state_r == st_exec && (op_r inside {x_to_acc_op, y_to_acc_op} ||
             (mode_r == mode_acc && writes_mem(op_r, mode_impl))))
      acc_r <= alu_res;
  end

  // index registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) x_r <= ACC_RST;
    else if (idle && i_reg_load && i_reg_sel == SEL_X) x_r <= i_reg_val;
    else if (state_r == st_exec && op_r inside {acc_to_x_op, sp_to_x_op,
             x_increment_op, x_decrement_op}) x_r <= alu_res;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) y_r <= ACC_RST;
    else if (idle && i_reg_load && i_reg_sel == SEL_Y) y_r <= i_reg_val;
    else if (state_r == st_exec && op_r inside {acc_to_y_op, y_increment_op,
             y_decrement_op}) y_r <= alu_res;
  end

  // stack pointer: push stores then decrements, pull increments then reads
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) sp_r <= SP_RST;
    else if (idle && i_reg_load && i_reg_sel == SEL_SP) sp_r <= i_reg_val;
    else if (state_r == st_exec && op_r == x_to_sp_op) sp_r <= x_r;
    else if (state_r inside {st_pushhi, st_pushlo}) sp_r <= sp_r - BYTE_ONE;
    else if (state_r inside {st_pulllo, st_pullhi}) sp_r <= sp_r + BYTE_ONE;
  end

  // status flags; the transfer into the stack pointer leaves them alone
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) status_r <= STATUS_RST;
    else if (state_r == st_pulllo && op_r == pull_status_op)
      status_r <= i_mem_rdata;
    else if (state_r == st_pulllo && op_r == pull_acc_op) begin
      status_r[FLAG_N] <= i_mem_rdata[DW-1];
      status_r[FLAG_Z] <= (i_mem_rdata == '0);
    end else if (state_r == st_exec) begin
      unique case (op_r)
        carry_clear_op: status_r[FLAG_C] <= 1'b0;
        carry_set_op: status_r[FLAG_C] <= 1'b1;
        decimal_clear_op: status_r[FLAG_D] <= 1'b0;
        decimal_set_op: status_r[FLAG_D] <= 1'b1;
        irq_mask_clear_op: status_r[FLAG_I] <= 1'b0;
        irq_mask_set_op: status_r[FLAG_I] <= 1'b1;
        overflow_clear_op: status_r[FLAG_V] <= 1'b0;
        default: status_r[FLAG_C] <= (alu_fn inside {alu_shl, alu_shr, alu_rotl,
                                      alu_rotr, alu_sub}) ? alu_c : status_r[FLAG_C];
      endcase
      if (sets_nz(op_r)) begin
        status_r[FLAG_N] <= alu_n;
        status_r[FLAG_Z] <= alu_z;
      end
    end
  end

  // memory strobes are decoded from the current step, so they last one cycle
  always_comb begin
    o_mem_addr = pc_r;
    o_mem_wdata = val_r;
    unique case (state_r)
      st_ptrlo: o_mem_addr = ptr_r;
      st_ptrhi: o_mem_addr = (mode_r == mode_ind) ? ptr_r + ADDR_ONE :
                             {ZERO_PAGE, ptr_r[DW-1:0] + BYTE_ONE};
      st_read, st_write: o_mem_addr = ea_r;
      st_pushhi: begin
        o_mem_addr = {STACK_PAGE, sp_r};
        o_mem_wdata = pc_r[AW-1:DW];
      end
      st_pushlo: begin
        o_mem_addr = {STACK_PAGE, sp_r};
        o_mem_wdata = (op_r == push_acc_op) ? acc_r :
                      (op_r == push_status_op) ? status_r : pc_r[DW-1:0];
      end
      st_pulllo, st_pullhi: o_mem_addr = {STACK_PAGE, sp_r + BYTE_ONE};
      default: ;
    endcase
  end

  assign o_mem_rd = state_r inside {st_oplo, st_ophi, st_ptrlo, st_ptrhi, st_read,
                                    st_pulllo, st_pullhi};
  assign o_mem_wr = state_r inside {st_write, st_pushhi, st_pushlo};
  assign o_busy = !idle;
  assign o_done = done_r;
  assign o_pc = pc_r;
  assign o_acc = acc_r;
  assign o_x = x_r;
  assign o_y = y_r;
  assign o_sp = sp_r;
  assign o_status = status_r;
  assign o_ea = ea_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_start_nofetch;
    idle && i_start && i_mode inside {mode_acc, mode_impl} &&
      !(i_op inside {push_acc_op, push_status_op, pull_acc_op, pull_status_op, return_sub_op});
  endsequence
  sequence s_exec_done;
    state_r == st_exec && !o_mem_rd ##1 o_done;
  endsequence

  property p_acc_mode;
    s_start_nofetch |=> s_exec_done;
  endproperty
  a_acc_mode: assert property (p_acc_mode) else $error("no-operand mode fetched");

  property p_imm;
    state_r == st_oplo && mode_r == mode_imm |=> state_r == st_exec &&
      val_r == $past(i_mem_rdata) && !o_mem_rd;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");

  property p_abs;
    state_r == st_ophi && mode_r == mode_abs |=> ea_r == {$past(i_mem_rdata), $past(lo_r)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute address wrong");

  property p_zp_index;
    state_r == st_oplo && mode_r inside {mode_zp, mode_zpx, mode_zpy} |=>
      ea_r[AW-1:DW] == ZERO_PAGE;
  endproperty
  a_zp_index: assert property (p_zp_index) else $error("zero page left");

  property p_absx;
    state_r == st_ophi && mode_r == mode_absx |=>
      ea_r == {$past(i_mem_rdata), $past(lo_r)} + {ZERO_PAGE, $past(x_r)};
  endproperty
  a_absx: assert property (p_absx) else $error("indexed absolute wrong");

  property p_branch;
    state_r == st_exec && taken |=> pc_r == $past(pc_r) + {{DW{$past(val_r[DW-1])}},
      $past(val_r)};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_indx_ptr;
    state_r == st_ptrhi && mode_r == mode_indx |->
      o_mem_addr == {ZERO_PAGE, ptr_r[DW-1:0] + BYTE_ONE} && ptr_r[AW-1:DW] == ZERO_PAGE;
  endproperty
  a_indx_ptr: assert property (p_indx_ptr) else $error("pointer left page zero");

  property p_ind_pc;
    state_r == st_ptrhi && mode_r == mode_ind |=> pc_r == {$past(i_mem_rdata), $past(lo_r)}
      && idle && o_done;
  endproperty
  a_ind_pc: assert property (p_ind_pc) else $error("indirect jump wrong");

  property p_compare_keep;
    state_r == st_exec && op_r inside {compare_acc_op, compare_x_op, compare_y_op} |=>
      $stable(acc_r) && $stable(x_r) && $stable(y_r);
  endproperty
  a_compare_keep: assert property (p_compare_keep) else $error("compare changed reg");

  property p_push;
    state_r == st_pushlo |-> o_mem_wr && o_mem_addr[AW-1:DW] == STACK_PAGE ##1
      sp_r == $past(sp_r) - BYTE_ONE;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
endmodule : coag_core

// [test/coag_mem_model.sv]
`timescale 1ns/1ns
module coag_mem_model (
  // memory bus from the core
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // read data, asynchronous
  output logic [7:0] o_rdata
);
  logic [7:0] m [0:65535];
  // a released bus shows the inverse, so a read outside the strobe is caught
  assign o_rdata = i_rd ? m[i_addr] : ~m[i_addr];
  // byte written at the edge that closes the strobe cycle
  always @(posedge i_clk) begin
    if (i_wr) begin
      m[i_addr] <= i_wdata;
    end
  end
endmodule : coag_mem_model

// [test/tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top;
  import coag_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, pcl = 0, rgl = 0, rd, wr, busy, done;
  coag_op_t op = nop_op;
  coag_mode_t md = mode_impl;
  logic [15:0] pcv = 16'h0000, addr, pc, ea;
  logic [1:0] sel = 2'h0;
  logic [7:0] rv = 8'h00, rdat, wdat, acc, x, y, sp, st;
  int bad_count = 0, cmp_count = 0;
  coag_core uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_op(op),
    .i_mode(md), .o_busy(busy), .o_done(done), .i_pc_load(pcl), .i_pc_val(pcv),
    .i_reg_load(rgl), .i_reg_sel(sel), .i_reg_val(rv), .o_mem_addr(addr),
    .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wdat), .i_mem_rdata(rdat),
    .o_pc(pc), .o_acc(acc), .o_x(x), .o_y(y), .o_sp(sp), .o_status(st), .o_ea(ea));
  coag_mem_model mem (.i_clk(clk), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdat), .o_rdata(rdat));
  // register loads take one idle edge each
  task automatic ld(input logic p, input logic [1:0] s, input logic [15:0] v);
    @(posedge clk);
    pcl <= p;
    rgl <= !p;
    sel <= s;
    pcv <= v;
    rv <= v[7:0];
    @(posedge clk);
    pcl <= 1'b0;
    rgl <= 1'b0;
  endtask : ld
  // done is sampled at the falling edge, clear of the update race
  task automatic run(input coag_op_t o, input coag_mode_t m);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    md <= m;
    @(posedge clk);
    start <= 1'b0;
    do @(negedge clk); while (done !== 1'b1 && ++n < 40);
    `CHK(n < 40, 1'b1)
  endtask : run
  task automatic t_jump();
    mem.m[16'h0200] = 8'h34;
    mem.m[16'h0201] = 8'h12;
    mem.m[16'h1234] = 8'h00;
    mem.m[16'h1235] = 8'h07;
    mem.m[16'h0700] = 8'h78;
    mem.m[16'h0701] = 8'h56;
    ld(1'b1, 2'h0, 16'h0200);
    run(jump_op, mode_abs);
    `CHK(pc, 16'h1234)
    run(jump_op, mode_ind);
    `CHK(pc, 16'h5678)
    $display("jump test done");
  endtask : t_jump
  // base 12f0 plus 20 crosses into page 13
  task automatic t_absx();
    mem.m[16'h0300] = 8'hf0;
    mem.m[16'h0301] = 8'h12;
    mem.m[16'h1310] = 8'h7f;
    ld(1'b0, SEL_X, 16'h0020);
    ld(1'b1, 2'h0, 16'h0300);
    run(mem_increment_op, mode_absx);
    `CHK(ea, 16'h1310)
    `CHK(mem.m[16'h1310], 8'h80)
    $display("indexed absolute test done");
  endtask : t_absx
  // f0 plus 20 must wrap inside page zero
  task automatic t_zpx();
    mem.m[16'h0400] = 8'hf0;
    mem.m[16'h0010] = 8'h05;
    ld(1'b0, SEL_ACC, 16'h0005);
    ld(1'b1, 2'h0, 16'h0400);
    run(compare_acc_op, mode_zpx);
    `CHK(ea, 16'h0010)
    `CHK({acc, st[FLAG_Z]}, 9'h00b)
    $display("zero page indexed test done");
  endtask : t_zpx
  // zero flag still set from the compare, offset -2 from the next pc
  task automatic t_branch();
    mem.m[16'h0500] = 8'hfe;
    ld(1'b1, 2'h0, 16'h0500);
    run(branch_zero, mode_rel);
    `CHK(pc, 16'h04ff)
    $display("branch test done");
  endtask : t_branch
  // clear/set pairs for carry, decimal and irq mask in enum order
  task automatic t_flags();
    for (int i = 0; i < 6; i++) begin
      run(coag_op_t'(i + 1), mode_impl);
      `CHK(st[i < 2 ? FLAG_C : (i < 4 ? FLAG_D : FLAG_I)], i[0])
    end
    $display("flag test done");
  endtask : t_flags
  // push 05 to 01ff, copy the pointer to X, pull it back into a cleared A
  task automatic t_stack();
    run(push_acc_op, mode_impl);
    `CHK({sp, mem.m[16'h01ff]}, 16'hfe05)
    run(sp_to_x_op, mode_impl);
    run(acc_to_y_op, mode_impl);
    `CHK({x, y}, 16'hfe05)
    ld(1'b0, SEL_ACC, 16'h0000);
    run(pull_acc_op, mode_impl);
    `CHK({acc, sp}, 16'h05ff)
    run(shift_left_op, mode_acc);
    `CHK({acc, st[FLAG_C]}, 9'h014)
    $display("stack test done");
  endtask : t_stack
  // pointer 12f0 plus Y=20 carries into the high byte; then immediate fe vs X
  task automatic t_indirect();
    mem.m[16'h0600] = 8'h40;
    mem.m[16'h0601] = 8'hfe;
    mem.m[16'h0040] = 8'hf0;
    mem.m[16'h0041] = 8'h12;
    ld(1'b0, SEL_Y, 16'h0020);
    ld(1'b1, 2'h0, 16'h0600);
    run(compare_y_op, mode_indy);
    `CHK(ea, 16'h1310)
    run(compare_x_op, mode_imm);
    `CHK({pc, st[FLAG_Z]}, 17'h00c05)
    $display("indirect test done");
  endtask : t_indirect
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    forever #4 clk = ~clk;
  end
  // the tests need about a hundred cycles
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_jump();
    t_absx();
    t_zpx();
    t_branch();
    t_flags();
    t_stack();
    t_indirect();
    end_of_test();
  end
endmodule : tb_top
